//--- verification/mies_exec_monitor.sv
`timescale 1ns/10ps

// ****
// exec slice checker
// ****
module mies_exec_monitor
  import mies_pkg::*;
#(
  parameter int unsigned PC_W = 13
)
(
  input wire logic            CLK,
  input wire logic            RESET,
  input wire logic            S_AXI_BVALID,
  input wire logic [PC_W-1:0] STACK_TOP,
  input wire logic            STACK_POP,
  input wire logic            PC_LOAD,
  input wire logic [PC_W-1:0] PC_VALUE,
  input wire logic            WATCHDOG_COUNTER_CLEAR,
  input wire logic            PRESCALER_CLEAR,
  input wire logic            OSC_STOP,
  input wire logic            WAKE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  chk_pop_load_pair: assert property (
    STACK_POP == PC_LOAD) else $error("pop and pc load differ");
  chk_pc_from_top: assert property (
    PC_LOAD |-> PC_VALUE == $past(STACK_TOP))
    else $error("pc not loaded from stack top");
  chk_pop_one_cycle: assert property (
    STACK_POP |=> !STACK_POP) else $error("pop longer than one cycle");
  chk_pop_at_commit: assert property (
    $rose(STACK_POP) |-> $rose(S_AXI_BVALID))
    else $error("pop not at commit edge");
  chk_clear_at_commit: assert property (
    $rose(WATCHDOG_COUNTER_CLEAR) |-> $rose(S_AXI_BVALID))
    else $error("sleep not done at commit edge");
  chk_clear_pair: assert property (
    WATCHDOG_COUNTER_CLEAR == PRESCALER_CLEAR)
    else $error("watchdog and prescaler clears differ");
  chk_clear_one_cycle: assert property (
    WATCHDOG_COUNTER_CLEAR |=> !WATCHDOG_COUNTER_CLEAR)
    else $error("clear longer than one cycle");
  chk_sleep_stops_osc: assert property (
    WATCHDOG_COUNTER_CLEAR |-> OSC_STOP) else $error("sleep kept osc on");
  chk_stop_holds: assert property (
    OSC_STOP && !WAKE && !$past(WAKE) && !$past(WAKE, 2)
    && !$past(WAKE, 3) |=> OSC_STOP) else $error("osc woke without wake");
  chk_wake_ends_sleep: assert property (
    $rose(WAKE) && OSC_STOP |-> ##[1:5] !OSC_STOP)
    else $error("wake did not end sleep");
  chk_asleep_no_pop: assert property (
    OSC_STOP |-> !STACK_POP) else $error("return ran while asleep");

  cov_return: cover property (STACK_POP);
  cov_sleep: cover property (WATCHDOG_COUNTER_CLEAR);
  cov_wake: cover property ($fell(OSC_STOP));
endmodule // mies_exec_monitor

bind mies_exec mies_exec_monitor #(.PC_W(PC_W)) i_mies_exec_monitor (
  .CLK, .RESET, .S_AXI_BVALID, .STACK_TOP, .STACK_POP, .PC_LOAD,
  .PC_VALUE, .WATCHDOG_COUNTER_CLEAR, .PRESCALER_CLEAR, .OSC_STOP, .WAKE);

//--- verification/tb_top.sv
`timescale 1ns/10ps

// ****
// exec slice bench
// ****
module tb_top;
  import mies_pkg::*;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic [11:0] S_AXI_AWADDR = 12'h000;
  logic        S_AXI_AWVALID = 1'b0;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_WVALID = 1'b0;
  logic        S_AXI_BREADY = 1'b0;
  logic [11:0] S_AXI_ARADDR = 12'h000;
  logic        S_AXI_ARVALID = 1'b0;
  logic        S_AXI_RREADY = 1'b0;
  logic [12:0] STACK_TOP = 13'h0000;
  logic        WAKE = 1'b0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, STACK_POP, PC_LOAD, OSC_STOP;
  logic        WATCHDOG_COUNTER_CLEAR, PRESCALER_CLEAR;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [31:0] S_AXI_RDATA, rdv;
  logic [12:0] PC_VALUE;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          pop_n = 0;
  int          clr_n = 0;
  logic        c_e = 1'b0, dc_e = 1'b0, z_e = 1'b0, pd_e = 1'b1, to_e = 1'b1;

  always #25 CLK = ~CLK;
  always @(posedge CLK) begin
    if (STACK_POP === 1'b1) pop_n++;
    if (WATCHDOG_COUNTER_CLEAR === 1'b1 && PRESCALER_CLEAR === 1'b1) clr_n++;
  end

  mies_exec i_mies_exec (.CLK, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .STACK_TOP, .STACK_POP, .PC_LOAD, .PC_VALUE, .WATCHDOG_COUNTER_CLEAR,
    .PRESCALER_CLEAR, .OSC_STOP, .WAKE);

  // ****
  // bus and check tasks
  // ****
  task automatic close_out;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID === 1'b1) break;
    end
    if (n == 40) begin
      fail_count++;
      close_out();
    end
    rsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID === 1'b1) break;
    end
    if (n == 40) begin
      fail_count++;
      close_out();
    end
    rdv = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic exec(input logic [3:0] op, input logic d,
                      input logic [7:0] k);
    wr(OFS_INSTR, {16'h0, op, 3'h0, d, k});
  endtask

  function automatic logic [31:0] st();
    return {27'h0, to_e, pd_e, z_e, dc_e, c_e};
  endfunction

  task automatic run_op(input logic [3:0] op, input logic d,
                        input logic [7:0] k, a, f);
    logic [7:0]  r, src, ea, ef;
    logic        fop;
    logic [11:0] fa;
    fa = OFS_FILE_BASE + {3'h0, k[6:0], 2'h0};
    fop = (op == 4'h4) || (op == 4'h6) || (op == 4'h7);
    src = fop ? f : k;
    wr(OFS_ACC, {24'h0, a});
    wr(fa, {24'h0, f});
    exec(op, d, k);
    case (op)
      4'h3, 4'h4: begin
        r = src - a;
        c_e = src >= a;
        dc_e = src[3:0] >= a[3:0];
        z_e = r == 8'h00;
      end
      4'h5, 4'h6: begin
        r = src ^ a;
        z_e = r == 8'h00;
      end
      default: r = {f[3:0], f[7:4]};
    endcase
    ea = (fop && d) ? a : r;
    ef = (fop && d) ? r : f;
    rd(OFS_ACC);
    chk("acc", {24'h0, ea}, rdv);
    rd(fa);
    chk("file", {24'h0, ef}, rdv);
    rd(OFS_STATUS);
    chk("status", st(), rdv);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_sub_lit;
    run_op(4'h3, 1'b0, 8'h10, 8'h01, 8'h00);
    run_op(4'h3, 1'b0, 8'h05, 8'h05, 8'h00);
    run_op(4'h3, 1'b0, 8'h00, 8'h01, 8'h00);
    run_op(4'h3, 1'b0, 8'hFF, 8'h00, 8'h00);
  endtask

  task automatic t_sub_file;
    run_op(4'h4, 1'b0, 8'h7F, 8'h01, 8'h80);
    run_op(4'h4, 1'b1, 8'h00, 8'h3C, 8'h3C);
  endtask

  task automatic t_xor;
    run_op(4'h3, 1'b0, 8'h55, 8'h11, 8'h00);
    run_op(4'h5, 1'b0, 8'h5A, 8'h5A, 8'h00);
    run_op(4'h6, 1'b1, 8'h7F, 8'h0F, 8'hF0);
    run_op(4'h6, 1'b0, 8'h40, 8'h33, 8'h33);
  endtask

  task automatic t_swap;
    run_op(4'h7, 1'b0, 8'h01, 8'h99, 8'hA5);
    run_op(4'h7, 1'b1, 8'h40, 8'h99, 8'h1E);
  endtask

  task automatic t_return;
    int p0;
    p0 = pop_n;
    STACK_TOP <= 13'h1ABC;
    exec(4'h1, 1'b0, 8'h00);
    chk("pops", 32'(p0 + 1), 32'(pop_n));
    chk("pc", 32'h1ABC, {19'h0, PC_VALUE});
    rd(OFS_STATUS);
    chk("status", st(), rdv);
  endtask

  task automatic t_sleep;
    int c0, n;
    c0 = clr_n;
    wr(OFS_ACC, 32'h77);
    exec(4'h2, 1'b0, 8'h00);
    pd_e = 1'b0;
    to_e = 1'b1;
    chk("clears", 32'(c0 + 1), 32'(clr_n));
    chk("stop", 32'h1, {31'h0, OSC_STOP});
    rd(OFS_STATUS);
    chk("status", st() | (32'h1 << ST_BUSY), rdv);
    exec(4'h5, 1'b0, 8'hFF);
    rd(OFS_ACC);
    chk("acc", 32'h77, rdv);
    WAKE <= 1'b1;
    for (n = 0; n < 20 && OSC_STOP !== 1'b0; n++) @(posedge CLK);
    if (n == 20) begin
      fail_count++;
      close_out();
    end
    WAKE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic t_bus_err;
    wr(12'h0F0, 32'h1);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rd(12'h0F0);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("rdata", 32'h0, rdv);
  endtask

  task automatic t_bad_op;
    exec(4'h9, 1'b0, 8'h00);
    rd(OFS_STATUS);
    chk("badop", st() | (32'h1 << ST_BADOP), rdv);
    wr(OFS_STATUS, st() | (32'h1 << ST_BADOP));
    rd(OFS_STATUS);
    chk("badclr", st(), rdv);
  endtask

  initial begin
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    rd(OFS_STATUS);
    chk("status", st(), rdv);
    t_sub_lit();
    t_sub_file();
    t_xor();
    t_swap();
    t_return();
    t_bad_op();
    t_sleep();
    t_bus_err();
    close_out();
  end
endmodule // tb_top

//--- verilog/mies_alu.sv
`timescale 1ns/10ps

module mies_alu
  import mies_pkg::*;
(
  input  wire mies_op_e   op,
  input  wire logic       dest,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] fval,
  input  wire logic [7:0] lit,
  output logic      [7:0] res,
  output logic            c,
  output logic            dc,
  output logic            z,
  output logic            upd_cdc,
  output logic            upd_z,
  output logic            wr_acc,
  output logic            wr_file,
  output logic            known
);

  // ****************************************
  // subtract by adding the complement
  // ****************************************
  logic [7:0] minuend;
  logic [8:0] diff;
  logic [4:0] half;
  logic       is_file;

  assign minuend = (op == OP_SUB_ACC_FROM_LITERAL) ? lit : fval;
  assign diff = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
  assign half = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  assign c  = diff[8];
  assign dc = half[4];
  assign z  = (res == 8'h00);

  assign is_file = (op == OP_SUB_ACC_FROM_FILE)
                 || (op == OP_XOR_ACC_WITH_FILE)
                 || (op == OP_NIBBLE_EXCHANGE);
  assign wr_file = is_file && dest;
  assign wr_acc  = (is_file && !dest)
                 || (op == OP_SUB_ACC_FROM_LITERAL)
                 || (op == OP_XOR_LITERAL_INTO_ACC);

  // ****************************************
  // result and flag selection
  // ****************************************
  always_comb begin
    res     = 8'h00;
    upd_cdc = 1'b0;
    upd_z   = 1'b0;
    known   = 1'b1;
    case (op)
      OP_SUB_ACC_FROM_LITERAL: begin
        res     = diff[7:0];
        upd_cdc = 1'b1;
        upd_z   = 1'b1;
      end
      OP_SUB_ACC_FROM_FILE: begin
        res     = diff[7:0];
        upd_cdc = 1'b1;
        upd_z   = 1'b1;
      end
      OP_XOR_LITERAL_INTO_ACC: begin
        res   = acc ^ lit;
        upd_z = 1'b1;
      end
      OP_XOR_ACC_WITH_FILE: begin
        res   = acc ^ fval;
        upd_z = 1'b1;
      end
      OP_NIBBLE_EXCHANGE: begin
        res = {fval[3:0], fval[7:4]};
      end
      OP_RETURN, OP_SLEEP: begin
        res = 8'h00;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

endmodule // mies_alu

//--- verilog/mies_exec.sv
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

// Function
// - Return pops, loads PC from stack top in two cycles, keeps flags.
// - Sleep clears the watchdog counter to zero and its prescaler.
// - Sleep clears the power-down bit and sets the timeout bit only.
// - After sleep the oscillator stops and execution halts until woken.
// - Literal minus accumulator goes to the accumulator; C, DC, Z update.
// - File minus accumulator, file address 0 to 127; C, DC, Z update.
// - Dest 0 sends a file result to the accumulator, dest 1 to the file.
// - Accumulator XOR literal goes to the accumulator; only Z updates.
// - Accumulator XOR file is routed by dest; only Z updates.
// - Nibble swap of the file byte is routed by dest; flags stay.

module mies_exec
  import mies_pkg::*;
#(
  parameter int unsigned FILE_DEPTH = 128,
  parameter int unsigned PC_W       = 13
)
(
  input  wire logic            CLK,
  input  wire logic            RESET,
  input  wire logic [11:0]     S_AXI_AWADDR,
  input  wire logic            S_AXI_AWVALID,
  output logic                 S_AXI_AWREADY,
  input  wire logic [31:0]     S_AXI_WDATA,
  input  wire logic [3:0]      S_AXI_WSTRB,
  input  wire logic            S_AXI_WVALID,
  output logic                 S_AXI_WREADY,
  output logic [1:0]           S_AXI_BRESP,
  output logic                 S_AXI_BVALID,
  input  wire logic            S_AXI_BREADY,
  input  wire logic [11:0]     S_AXI_ARADDR,
  input  wire logic            S_AXI_ARVALID,
  output logic                 S_AXI_ARREADY,
  output logic [31:0]          S_AXI_RDATA,
  output logic [1:0]           S_AXI_RRESP,
  output logic                 S_AXI_RVALID,
  input  wire logic            S_AXI_RREADY,
  input  wire logic [PC_W-1:0] STACK_TOP,
  output logic                 STACK_POP,
  output logic                 PC_LOAD,
  output logic [PC_W-1:0]      PC_VALUE,
  output logic                 WATCHDOG_COUNTER_CLEAR,
  output logic                 PRESCALER_CLEAR,
  output logic                 OSC_STOP,
  input  wire logic            WAKE
);

  // ****************************************
  // parameter check
  // ****************************************
  generate
    if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_bad_depth
      $error("FILE_DEPTH must lie in 1..128");
    end
    if (PC_W < 1 || PC_W > 32) begin : g_bad_pcw
      $error("PC_W must lie in 1..32");
    end
  endgenerate

  // ****************************************
  // state
  // ****************************************
  mies_state_e      state_ff;
  mies_state_e      nxt_state;
  logic [7:0]       acc_ff;
  logic [7:0]       nxt_acc;
  logic             c_ff;
  logic             nxt_c;
  logic             dc_ff;
  logic             nxt_dc;
  logic             z_ff;
  logic             nxt_z;
  logic             pd_ff;
  logic             nxt_pd;
  logic             to_ff;
  logic             nxt_to;
  logic             badop_ff;
  logic             nxt_badop;
  logic [PC_W-1:0]  pc_ff;
  logic [PC_W-1:0]  nxt_pc;
  logic             pop_ff;
  logic             wdt_clr_ff;
  logic             wake_meta_ff;
  logic             wake_sync_ff;
  logic [7:0]       file_ff [FILE_DEPTH];

  // ****************************************
  // bus slave state
  // ****************************************
  logic             aw_held_ff;
  logic [11:0]      aw_addr_ff;
  logic             w_held_ff;
  logic [31:0]      w_data_ff;
  logic [3:0]       w_strb_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;

  // ****************************************
  // write channel decode
  // ****************************************
  wire        aw_take   = S_AXI_AWVALID && S_AXI_AWREADY;
  wire        w_take    = S_AXI_WVALID && S_AXI_WREADY;
  wire        ar_take   = S_AXI_ARVALID && S_AXI_ARREADY;
  wire        wcommit   = aw_held_ff && w_held_ff && !bvalid_ff;
  wire [9:0]  w_word    = aw_addr_ff[11:2];
  wire [9:0]  base_word = OFS_FILE_BASE[11:2];
  wire [9:0]  w_foff    = w_word - base_word;
  wire        w_fhit    = (w_word >= base_word)
                        && (32'(w_foff) < FILE_DEPTH);
  wire        w_instr   = (w_word == OFS_INSTR[11:2]);
  wire        w_acc     = (w_word == OFS_ACC[11:2]);
  wire        w_status  = (w_word == OFS_STATUS[11:2]);
  wire        w_pc      = (w_word == OFS_PC[11:2]);
  wire        w_mapped  = w_instr || w_acc || w_status
                        || w_pc || w_fhit;
  wire        lane0     = w_strb_ff[0];
  wire        lane1     = w_strb_ff[1];
  wire        sw_acc    = wcommit && w_acc && lane0;
  wire        sw_status = wcommit && w_status && lane0;
  wire        sw_badclr = wcommit && w_status && lane1
                        && w_data_ff[ST_BADOP];
  wire        sw_file   = wcommit && w_fhit && lane0;
  wire [FADDR_W-1:0] sw_fidx = w_foff[FADDR_W-1:0];

  // ****************************************
  // instruction decode
  // ****************************************
  wire        running   = (state_ff == S_RUN);
  wire        exec_go   = wcommit && w_instr && lane0 && lane1
                        && running;
  wire [3:0]  op_bits   = w_data_ff[INSTR_OP_LSB +: 4];
  wire mies_op_e op     = exec_go ? mies_op_e'(op_bits) : OP_NONE;
  wire [7:0]  lit       = w_data_ff[INSTR_OPD_LSB +: 8];
  wire        dest      = w_data_ff[INSTR_DEST_BIT];
  wire [FADDR_W-1:0] faddr = lit[FADDR_W-1:0];
  wire        f_in      = (32'(faddr) < FILE_DEPTH);
  wire [7:0]  fval      = f_in ? file_ff[faddr] : 8'h00;
  wire        go_ret    = (op == OP_RETURN);
  wire        go_sleep  = (op == OP_SLEEP);

  // ****************************************
  // datapath
  // ****************************************
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_dc;
  logic       alu_z;
  logic       alu_upd_cdc;
  logic       alu_upd_z;
  logic       alu_wr_acc;
  logic       alu_wr_file;
  logic       alu_known;

  mies_alu u_alu (
    .op      (op),
    .dest    (dest),
    .acc     (acc_ff),
    .fval    (fval),
    .lit     (lit),
    .res     (alu_res),
    .c       (alu_c),
    .dc      (alu_dc),
    .z       (alu_z),
    .upd_cdc (alu_upd_cdc),
    .upd_z   (alu_upd_z),
    .wr_acc  (alu_wr_acc),
    .wr_file (alu_wr_file),
    .known   (alu_known)
  );

  wire ex_file = alu_wr_file && f_in;

  // ****************************************
  // next values
  // ****************************************
  assign nxt_acc = sw_acc ? w_data_ff[7:0]
                 : alu_wr_acc ? alu_res : acc_ff;
  assign nxt_c   = sw_status ? w_data_ff[ST_C]
                 : alu_upd_cdc ? alu_c : c_ff;
  assign nxt_dc  = sw_status ? w_data_ff[ST_DC]
                 : alu_upd_cdc ? alu_dc : dc_ff;
  assign nxt_z   = sw_status ? w_data_ff[ST_Z]
                 : alu_upd_z ? alu_z : z_ff;
  assign nxt_pd  = go_sleep ? 1'b0 : pd_ff;
  assign nxt_to  = go_sleep ? 1'b1 : to_ff;
  assign nxt_pc  = go_ret ? STACK_TOP : pc_ff;
  assign nxt_badop = (exec_go && !alu_known)
                   || (badop_ff && !sw_badclr);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_RUN: begin
        if (go_ret) begin
          nxt_state = S_RET;
        end else if (go_sleep) begin
          nxt_state = S_SLEEP;
        end else begin
          nxt_state = S_RUN;
        end
      end
      S_RET: begin
        nxt_state = S_RUN;
      end
      S_SLEEP: begin
        if (wake_sync_ff) begin
          nxt_state = S_RUN;
        end
      end
      default: begin
        nxt_state = S_RUN;
      end
    endcase
  end

  // ****************************************
  // core registers
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_ff   <= S_RUN;
      acc_ff     <= ACC_RST;
      c_ff       <= FLAG_RST;
      dc_ff      <= FLAG_RST;
      z_ff       <= FLAG_RST;
      pd_ff      <= PD_RST;
      to_ff      <= TO_RST;
      badop_ff   <= FLAG_RST;
      pc_ff      <= '0;
      pop_ff     <= 1'b0;
      wdt_clr_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      acc_ff     <= nxt_acc;
      c_ff       <= nxt_c;
      dc_ff      <= nxt_dc;
      z_ff       <= nxt_z;
      pd_ff      <= nxt_pd;
      to_ff      <= nxt_to;
      badop_ff   <= nxt_badop;
      pc_ff      <= nxt_pc;
      pop_ff     <= go_ret;
      wdt_clr_ff <= go_sleep;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wake_meta_ff <= 1'b0;
      wake_sync_ff <= 1'b0;
    end else begin
      wake_meta_ff <= WAKE;
      wake_sync_ff <= wake_meta_ff;
    end
  end

  // ****************************************
  // file registers
  // ****************************************
  generate
    for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
      wire sw_hit = sw_file && (32'(sw_fidx) == i);
      wire ex_hit = ex_file && (32'(faddr) == i);
      wire [7:0] nxt_file = sw_hit ? w_data_ff[7:0]
                          : ex_hit ? alu_res : file_ff[i];
      always_ff @(posedge CLK) begin
        if (RESET) begin
          file_ff[i] <= FILE_RST;
        end else begin
          file_ff[i] <= nxt_file;
        end
      end
    end
  endgenerate

  // ****************************************
  // write channels
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
    end else if (aw_take) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= S_AXI_AWADDR;
    end else if (wcommit) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
    end else if (w_take) begin
      w_held_ff <= 1'b1;
      w_data_ff <= S_AXI_WDATA;
      w_strb_ff <= S_AXI_WSTRB;
    end else if (wcommit) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wcommit) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  wire [9:0]  r_word   = S_AXI_ARADDR[11:2];
  wire [9:0]  r_foff   = r_word - base_word;
  wire        r_fhit   = (r_word >= base_word)
                       && (32'(r_foff) < FILE_DEPTH);
  wire [FADDR_W-1:0] r_fidx = r_foff[FADDR_W-1:0];
  wire [31:0] status_w = {21'h0, badop_ff, !running && !OSC_STOP,
                          !running, 3'h0, to_ff, pd_ff, z_ff,
                          dc_ff, c_ff};
  wire        r_status = (r_word == OFS_STATUS[11:2]);
  wire        r_acc    = (r_word == OFS_ACC[11:2]);
  wire        r_pc     = (r_word == OFS_PC[11:2]);
  wire        r_instr  = (r_word == OFS_INSTR[11:2]);
  wire        r_mapped = r_status || r_acc || r_pc
                       || r_instr || r_fhit;
  wire [31:0] rd_mux   = r_status ? status_w
                       : r_acc ? {24'h000000, acc_ff}
                       : r_pc ? 32'(pc_ff)
                       : r_fhit ? {24'h000000, file_ff[r_fidx]}
                       : 32'h00000000;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign S_AXI_AWREADY = !aw_held_ff && !bvalid_ff;
  assign S_AXI_WREADY  = !w_held_ff && !bvalid_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_ARREADY = !rvalid_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;
  assign STACK_POP     = pop_ff;
  assign PC_LOAD       = pop_ff;
  assign PC_VALUE      = pc_ff;
  assign WATCHDOG_COUNTER_CLEAR = wdt_clr_ff;
  assign PRESCALER_CLEAR        = wdt_clr_ff;
  assign OSC_STOP      = (state_ff == S_SLEEP);

endmodule // mies_exec

//--- verilog/mies_pkg.sv
package mies_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned AXI_AW        = 12;
  localparam logic [11:0] OFS_INSTR     = 12'h000;
  localparam logic [11:0] OFS_ACC       = 12'h004;
  localparam logic [11:0] OFS_STATUS    = 12'h008;
  localparam logic [11:0] OFS_PC        = 12'h00C;
  localparam logic [11:0] OFS_FILE_BASE = 12'h100;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned INSTR_OPD_LSB  = 0;
  localparam int unsigned INSTR_DEST_BIT = 8;
  localparam int unsigned INSTR_OP_LSB   = 12;
  localparam int unsigned FADDR_W        = 7;
  localparam int unsigned ST_C           = 0;
  localparam int unsigned ST_DC          = 1;
  localparam int unsigned ST_Z           = 2;
  localparam int unsigned ST_PD          = 3;
  localparam int unsigned ST_TO          = 4;
  localparam int unsigned ST_BUSY        = 8;
  localparam int unsigned ST_SLEEP       = 9;
  localparam int unsigned ST_BADOP       = 10;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] FILE_RST  = 8'h00;
  localparam logic       FLAG_RST  = 1'b0;
  localparam logic       PD_RST    = 1'b1;
  localparam logic       TO_RST    = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned RET_CYCLES  = 2;
  localparam int unsigned EXEC_CYCLES = 1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_RETURN   = 4'h1,
    OP_SLEEP    = 4'h2,
    OP_SUB_ACC_FROM_LITERAL = 4'h3,
    OP_SUB_ACC_FROM_FILE    = 4'h4,
    OP_XOR_LITERAL_INTO_ACC = 4'h5,
    OP_XOR_ACC_WITH_FILE    = 4'h6,
    OP_NIBBLE_EXCHANGE      = 4'h7
  } mies_op_e;

  typedef enum logic [2:0] {
    S_RUN   = 3'b001,
    S_RET   = 3'b010,
    S_SLEEP = 3'b100
  } mies_state_e;

endpackage
